// ---- bba_top.sv ----
// Purpose: APB-controlled execution datapath for byte and bit operations.
// Assumes: Single APB master; pclk at 100 MHz; presetn asynchronous.
// Notes: Writing CMD executes one instruction word; pready marks the end.
`timescale 1ns/1ps

// Function
// - Add an 8-bit literal to W, store the sum in W and update C, DC, Z.
// - Add W to the file register at a 7-bit address and update C, DC, Z.
// - Byte file operations store to W when d is 0 and to the file when 1.
// - AND W with an 8-bit literal and place the result in W.
// - AND W with the addressed file register, route by d, update only Z.
// - Bit clear forces the indexed bit of a file register to zero.
// - Bit set forces the indexed bit of a file register to one.
// - Test-skip-if-clear reads a file address and bit index and tests it.
// - A successful test takes two cycles, the second being a no-op.
// - A destination bit of 1 is the default and stores to the file.
module bba_top #(
	parameter int DEPTH = 128
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB request.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// APB answer.
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import bba_pkg::*;

	typedef struct packed {
		bba_state_e st;
		logic [13:0] instr;
		logic [7:0] w;
		logic c;
		logic dc;
		logic z;
		logic skip;
		logic bad;
		logic [6:0] faddr;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} bba_regs_s;

	bba_regs_s r;
	bba_regs_s next_r;
	logic [7:0] file_mem [DEPTH];
	logic mem_we;
	logic [6:0] mem_addr;
	logic [7:0] mem_wdata;
	logic access;
	logic [6:0] fidx;
	logic [2:0] bidx;
	bba_alu_in_s ain;
	bba_alu_out_s aout;

	assign fidx = r.instr[`BBA_FADR_HI:0];
	assign bidx = r.instr[`BBA_BIDX_HI:`BBA_BIDX_LO];
	assign access = psel & penable;

	always_comb begin
		ain.op = bba_decode(r.instr);
		ain.w = r.w;
		ain.f = file_mem[fidx];
		ain.k = r.instr[`BBA_LIT_HI:0];
		ain.bidx = bidx;
		ain.dest = r.instr[`BBA_DEST_BIT];
	end

	bba_alu u_alu (
		.a(ain),
		.y(aout)
	);

	always_comb begin
		next_r = r;
		mem_we = 1'b0;
		mem_addr = fidx;
		mem_wdata = aout.res;
		case (r.st)
			BBA_IDLE: begin
				if (access) begin
					next_r.pslverr = 1'b0;
					next_r.prdata = 32'h0000_0000;
					next_r.pready = 1'b1;
					next_r.st = BBA_RESP;
					case (paddr)
						`BBA_CMD_OFF: begin
							if (pwrite) begin
								next_r.instr = pwdata[13:0];
								next_r.pready = 1'b0;
								next_r.st = BBA_EXEC;
							end else begin
								next_r.prdata = {18'h0_0000, r.instr};
							end
						end
						`BBA_WREG_OFF: begin
							if (pwrite)
								next_r.w = pwdata[7:0];
							else
								next_r.prdata = {24'h00_0000, r.w};
						end
						`BBA_STAT_OFF: begin
							if (pwrite) begin
								next_r.c = pwdata[`BBA_STAT_C];
								next_r.dc = pwdata[`BBA_STAT_DC];
								next_r.z = pwdata[`BBA_STAT_Z];
							end else begin
								next_r.prdata = {27'h000_0000, r.bad,
									r.skip, r.z, r.dc, r.c};
							end
						end
						`BBA_FADDR_OFF: begin
							if (pwrite)
								next_r.faddr = pwdata[6:0];
							else
								next_r.prdata = {25'h000_0000, r.faddr};
						end
						`BBA_FDATA_OFF: begin
							if (pwrite) begin
								mem_we = 1'b1;
								mem_addr = r.faddr;
								mem_wdata = pwdata[7:0];
							end else begin
								next_r.prdata = {24'h00_0000,
									file_mem[r.faddr]};
							end
						end
						default: next_r.pslverr = 1'b1;
					endcase
				end
			end
			BBA_EXEC: begin
				if (aout.upd_c) begin
					next_r.c = aout.c;
					next_r.dc = aout.dc;
				end
				if (aout.upd_z)
					next_r.z = aout.z;
				if (aout.wr_w)
					next_r.w = aout.res;
				mem_we = aout.wr_f;
				next_r.skip = aout.skip;
				next_r.bad = (ain.op == BBA_OP_NONE);
				// A taken skip costs one extra idle cycle.
				if (aout.skip) begin
					next_r.st = BBA_NOPC;
				end else begin
					next_r.pready = 1'b1;
					next_r.st = BBA_RESP;
				end
			end
			BBA_NOPC: begin
				next_r.pready = 1'b1;
				next_r.st = BBA_RESP;
			end
			BBA_RESP: begin
				next_r.pready = 1'b0;
				next_r.pslverr = 1'b0;
				next_r.st = BBA_IDLE;
			end
			default: next_r.st = BBA_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.st <= BBA_IDLE;
			r.instr <= `BBA_CMD_RST;
			r.w <= `BBA_W_RST;
			r.c <= 1'b0;
			r.dc <= 1'b0;
			r.z <= 1'b0;
			r.skip <= 1'b0;
			r.bad <= 1'b0;
			r.faddr <= `BBA_FADDR_RST;
			r.prdata <= 32'h0000_0000;
			r.pready <= 1'b0;
			r.pslverr <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	// The file array has no reset; software initialises what it uses.
	always_ff @(posedge pclk) begin
		if (mem_we)
			file_mem[mem_addr] <= mem_wdata;
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;

	// Reference sum built apart from the function unit.
	logic [8:0] ref_sum;
	logic [4:0] ref_half;
	assign ref_sum = {1'b0, r.w} + {1'b0, (ain.op == BBA_OP_ADD_IMM) ?
		ain.k : ain.f};
	assign ref_half = {1'b0, r.w[3:0]} + {1'b0, (ain.op == BBA_OP_ADD_IMM) ?
		ain.k[3:0] : ain.f[3:0]};

	add_imm_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.st == BBA_EXEC && ain.op == BBA_OP_ADD_IMM |=>
		r.w == $past(ref_sum[7:0]) && r.c == $past(ref_sum[8]))
		else $error("Literal add gave a wrong sum or carry.");

	add_file_flags_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		r.st == BBA_EXEC && ain.op == BBA_OP_ADD_FILE |=>
		r.c == $past(ref_sum[8]) && r.dc == $past(ref_half[4]))
		else $error("File add gave wrong carry flags.");

	dest_file_w_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.st == BBA_EXEC && ain.dest == `BBA_DEST_FILE &&
		(ain.op == BBA_OP_ADD_FILE || ain.op == BBA_OP_AND_FILE) |=>
		$stable(r.w) && file_mem[$past(fidx)] == $past(aout.res))
		else $error("File destination did not store to the file.");

	and_imm_res_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.st == BBA_EXEC && ain.op == BBA_OP_AND_IMM |=>
		r.w == ($past(r.w) & $past(ain.k)))
		else $error("Literal AND gave a wrong result.");

	and_file_flags_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		r.st == BBA_EXEC && ain.op == BBA_OP_AND_FILE |=>
		$stable(r.c) && $stable(r.dc))
		else $error("File AND changed carry flags.");

	bit_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.st == BBA_EXEC && ain.op == BBA_OP_BIT_CLR |=>
		file_mem[$past(fidx)][$past(bidx)] == 1'b0 && $stable(r.z))
		else $error("Bit clear left the bit set.");

	bit_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.st == BBA_EXEC && ain.op == BBA_OP_BIT_SET |=>
		file_mem[$past(fidx)][$past(bidx)] == 1'b1 && $stable(r.c))
		else $error("Bit set left the bit clear.");

	skip_two_cyc_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.st == BBA_EXEC && ain.op == BBA_OP_TEST_CLR &&
		ain.f[bidx] == 1'b0 |=> !pready ##1 pready && r.skip)
		else $error("Taken skip did not add one no-op cycle.");

	zero_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.st == BBA_EXEC && aout.upd_z |=> r.z == ($past(aout.res) == 8'h00))
		else $error("Zero flag disagrees with the result.");

endmodule : bba_top

// ---- bba_defines.svh ----
// Purpose: Offsets, field positions, reset values and opcode codes.
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses.
// Notes: Definitions only; included by the package.
`ifndef BBA_DEFINES_SVH
`define BBA_DEFINES_SVH

// Register byte offsets on the bus.
`define BBA_CMD_OFF 8'h00
`define BBA_WREG_OFF 8'h04
`define BBA_STAT_OFF 8'h08
`define BBA_FADDR_OFF 8'h0C
`define BBA_FDATA_OFF 8'h10

// Status register bit positions.
`define BBA_STAT_C 0
`define BBA_STAT_DC 1
`define BBA_STAT_Z 2
`define BBA_STAT_SKIP 3
`define BBA_STAT_BAD 4

// Reset values.
`define BBA_W_RST 8'h00
`define BBA_CMD_RST 14'h0000
`define BBA_FADDR_RST 7'h00

// Instruction word fields.
`define BBA_CLASS_HI 13
`define BBA_CLASS_LO 12
`define BBA_DEST_BIT 7
`define BBA_BIDX_HI 9
`define BBA_BIDX_LO 7
`define BBA_FADR_HI 6
`define BBA_LIT_HI 7

// Opcode codes.
`define BBA_CLASS_BYTE 2'h0
`define BBA_CLASS_BIT 2'h1
`define BBA_CLASS_LIT 2'h3
`define BBA_SUB_ADDF 4'h7
`define BBA_SUB_ANDF 4'h5
`define BBA_SUB_BCLR 2'h0
`define BBA_SUB_BSET 2'h1
`define BBA_SUB_BTSC 2'h2
`define BBA_SUB_ADDL 3'h7
`define BBA_SUB_ANDL 4'h9

// Destination select: 1 returns the result to the file register.
`define BBA_DEST_FILE 1'b1

`endif

// ---- bba_pkg.sv ----
// Purpose: Types and instruction decode shared by the datapath files.
// Assumes: bba_defines.svh is on the include path.
// Notes: Unsupported encodings decode to BBA_OP_NONE.
package bba_pkg;
`include "bba_defines.svh"

	typedef enum logic [2:0] {
		BBA_OP_NONE,
		BBA_OP_ADD_IMM,
		BBA_OP_ADD_FILE,
		BBA_OP_AND_IMM,
		BBA_OP_AND_FILE,
		BBA_OP_BIT_CLR,
		BBA_OP_BIT_SET,
		BBA_OP_TEST_CLR
	} bba_op_e;

	typedef enum logic [1:0] {
		BBA_IDLE,
		BBA_EXEC,
		BBA_NOPC,
		BBA_RESP
	} bba_state_e;

	typedef struct packed {
		bba_op_e op;
		logic [7:0] w;
		logic [7:0] f;
		logic [7:0] k;
		logic [2:0] bidx;
		logic dest;
	} bba_alu_in_s;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic dc;
		logic z;
		logic upd_c;
		logic upd_z;
		logic wr_w;
		logic wr_f;
		logic skip;
	} bba_alu_out_s;

	function automatic bba_op_e bba_decode(input logic [13:0] ins);
		bba_op_e op;
		op = BBA_OP_NONE;
		case (ins[`BBA_CLASS_HI:`BBA_CLASS_LO])
			`BBA_CLASS_BYTE: begin
				if (ins[11:8] == `BBA_SUB_ADDF)
					op = BBA_OP_ADD_FILE;
				else if (ins[11:8] == `BBA_SUB_ANDF)
					op = BBA_OP_AND_FILE;
			end
			`BBA_CLASS_BIT: begin
				case (ins[11:10])
					`BBA_SUB_BCLR: op = BBA_OP_BIT_CLR;
					`BBA_SUB_BSET: op = BBA_OP_BIT_SET;
					`BBA_SUB_BTSC: op = BBA_OP_TEST_CLR;
					default: op = BBA_OP_NONE;
				endcase
			end
			`BBA_CLASS_LIT: begin
				if (ins[11:9] == `BBA_SUB_ADDL)
					op = BBA_OP_ADD_IMM;
				else if (ins[11:8] == `BBA_SUB_ANDL)
					op = BBA_OP_AND_IMM;
			end
			default: op = BBA_OP_NONE;
		endcase
		return op;
	endfunction : bba_decode

endpackage : bba_pkg

// ---- bba_alu.sv ----
// Purpose: Combinational function unit for add, AND and bit operations.
// Assumes: Operands arrive already decoded in one struct.
// Notes: Pure logic; the caller decides when results are committed.
`timescale 1ns/1ps
module bba_alu (
	// Operands.
	input bba_pkg::bba_alu_in_s a,
	// Result and flag updates.
	output bba_pkg::bba_alu_out_s y
);
	import bba_pkg::*;

	logic [7:0] opnd;
	logic [8:0] sum;
	logic [4:0] half;
	logic [7:0] mask;

	always_comb begin
		opnd = (a.op == BBA_OP_ADD_IMM || a.op == BBA_OP_AND_IMM) ?
			a.k : a.f;
		// Sums wrap at eight bits; bit 8 is only the carry.
		sum = {1'b0, a.w} + {1'b0, opnd};
		half = {1'b0, a.w[3:0]} + {1'b0, opnd[3:0]};
		mask = 8'h01 << a.bidx;
		y = '0;
		case (a.op)
			BBA_OP_ADD_IMM, BBA_OP_ADD_FILE: begin
				y.res = sum[7:0];
				y.c = sum[8];
				y.dc = half[4];
				y.upd_c = 1'b1;
				y.upd_z = 1'b1;
			end
			BBA_OP_AND_IMM, BBA_OP_AND_FILE: begin
				y.res = a.w & opnd;
				y.upd_z = 1'b1;
			end
			BBA_OP_BIT_CLR: begin
				y.res = a.f & ~mask;
				y.wr_f = 1'b1;
			end
			BBA_OP_BIT_SET: begin
				y.res = a.f | mask;
				y.wr_f = 1'b1;
			end
			BBA_OP_TEST_CLR: begin
				y.res = a.f;
				y.skip = ~|(a.f & mask);
			end
			default: y.res = a.w;
		endcase
		y.z = (y.res == 8'h00);
		case (a.op)
			BBA_OP_ADD_IMM, BBA_OP_AND_IMM: y.wr_w = 1'b1;
			BBA_OP_ADD_FILE, BBA_OP_AND_FILE: begin
				y.wr_f = (a.dest == `BBA_DEST_FILE);
				y.wr_w = (a.dest != `BBA_DEST_FILE);
			end
			default: y.wr_w = 1'b0;
		endcase
	end

endmodule : bba_alu

// ---- tb.sv ----
// Purpose: Self-checking bench for the byte and bit datapath over APB.
// Assumes: Every transfer ends with a one-cycle pready pulse.
// Notes: The skip cycle is judged against a plain test of a set bit.
`timescale 1ns/1ps
`include "bba_defines.svh"
module tb;
	import bba_pkg::*;
	localparam logic [7:0] a_cmd = `BBA_CMD_OFF;
	localparam logic [7:0] a_w = `BBA_WREG_OFF;
	localparam logic [7:0] a_st = `BBA_STAT_OFF;
	localparam logic [7:0] a_fa = `BBA_FADDR_OFF;
	localparam logic [7:0] a_fd = `BBA_FDATA_OFF;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic [31:0] r;
	logic pready;
	logic pslverr;
	logic e;
	int err_count = 0;
	int total_checks = 0;
	int n;
	int n0;

	bba_top dut (
		.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr)
	);

	always #5 pclk = ~pclk;

	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] g, input logic [31:0] x, input string m);
		total_checks++;
		if (g !== x) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, x);
		end
	endtask : chk

	// The request stays put until pready is seen high at a rising edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED at %0t: no pready", $time);
			print_verdict;
		end else begin
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	task ex(input logic [13:0] ins);
		apb(1'b1, a_cmd, {18'h00000, ins});
	endtask : ex

	task setf(input logic [6:0] a, input logic [7:0] v);
		apb(1'b1, a_fa, {25'h0000000, a});
		apb(1'b1, a_fd, {24'h000000, v});
	endtask : setf

	task getf(input logic [6:0] a, input logic [7:0] x, input string m);
		apb(1'b1, a_fa, {25'h0000000, a});
		apb(1'b0, a_fd, 32'h00000000);
		chk(r, {24'h000000, x}, m);
	endtask : getf

	task cw(input logic [7:0] x, input string m);
		apb(1'b0, a_w, 32'h00000000);
		chk(r, {24'h000000, x}, m);
	endtask : cw

	task cst(input logic [4:0] x, input string m);
		apb(1'b0, a_st, 32'h00000000);
		chk(r, {27'h0000000, x}, m);
	endtask : cst

	task t_reset;
		cw(8'h00, "w reset");
		cst(5'h00, "status reset");
		apb(1'b0, a_fa, 32'h00000000);
		chk(r, 32'h00000000, "faddr reset");
		apb(1'b0, a_cmd, 32'h00000000);
		chk(r, 32'h00000000, "cmd reset");
		$display("test reset done");
	endtask : t_reset

	task t_add_imm;
		apb(1'b1, a_w, 32'h000000F8);
		ex(14'h3E0F);
		cw(8'h07, "add imm wrap");
		cst(5'h03, "add imm c dc");
		apb(1'b1, a_w, 32'h00000001);
		ex(14'h3FFF);
		cw(8'h00, "add imm zero");
		cst(5'h07, "add imm c dc z");
		apb(1'b1, a_w, 32'h00000010);
		ex(14'h3E20);
		cw(8'h30, "add imm plain");
		cst(5'h00, "add imm no flags");
		$display("test add immediate done");
	endtask : t_add_imm

	task t_add_file;
		setf(7'h7F, 8'h88);
		apb(1'b1, a_w, 32'h00000078);
		ex(14'h077F);
		cw(8'h00, "add file to w");
		getf(7'h7F, 8'h88, "file kept");
		cst(5'h07, "add file flags");
		apb(1'b1, a_w, 32'h00000001);
		ex(14'h07FF);
		getf(7'h7F, 8'h89, "add file to f");
		cw(8'h01, "w kept");
		cst(5'h00, "add file clear");
		$display("test add file done");
	endtask : t_add_file

	task t_and;
		apb(1'b1, a_st, 32'h00000003);
		apb(1'b1, a_w, 32'h000000F0);
		ex(14'h390F);
		cw(8'h00, "and imm");
		cst(5'h07, "and imm z only");
		setf(7'h05, 8'h3C);
		apb(1'b1, a_w, 32'h0000000F);
		ex(14'h0585);
		getf(7'h05, 8'h0C, "and file to f");
		cst(5'h03, "and file z clear");
		ex(14'h0505);
		cw(8'h0C, "and file to w");
		$display("test and done");
	endtask : t_and

	task t_bits;
		logic [7:0] x;
		setf(7'h40, 8'h00);
		apb(1'b1, a_st, 32'h00000007);
		x = 8'h00;
		for (int b = 0; b < 8; b++) begin
			ex({4'b0101, b[2:0], 7'h40});
			x[b] = 1'b1;
			getf(7'h40, x, "bit set");
		end
		for (int b = 0; b < 8; b++) begin
			ex({4'b0100, b[2:0], 7'h40});
			x[b] = 1'b0;
			getf(7'h40, x, "bit clear");
		end
		cst(5'h07, "bit ops keep flags");
		$display("test bit ops done");
	endtask : t_bits

	task t_skip;
		setf(7'h7F, 8'h80);
		apb(1'b1, a_st, 32'h00000000);
		ex({4'b0110, 3'd7, 7'h7F});
		n0 = n;
		chk(n0, 32'h00000003, "plain cmd cycles");
		cst(5'h00, "test set bit");
		ex({4'b0110, 3'd6, 7'h7F});
		chk(n, n0 + 1, "extra no-op cycle");
		cst(5'h08, "test clear bit");
		getf(7'h7F, 8'h80, "test leaves file");
		$display("test skip done");
	endtask : t_skip

	task t_refuse;
		apb(1'b0, 8'h14, 32'h00000000);
		chk({31'h0, e}, 32'h00000001, "unmapped error");
		apb(1'b1, a_w, 32'h00000055);
		chk({31'h0, e}, 32'h00000000, "mapped no error");
		ex(14'h2000);
		cst(5'h10, "bad opcode");
		cw(8'h55, "bad opcode keeps w");
		apb(1'b0, a_cmd, 32'h00000000);
		chk(r, 32'h00002000, "cmd readback");
		chk({31'h0, e}, 32'h00000000, "cmd read no error");
		$display("test refusals done");
	endtask : t_refuse

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_add_imm;
		t_add_file;
		t_and;
		t_bits;
		t_skip;
		t_refuse;
		// A second reset in mid-run must clear state that the tests left.
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		print_verdict;
	end
endmodule : tb
